// file: hw/dcpg_pkg.sv
// Constants and helpers shared by the dual channel pulse generator block
package dcpg_pkg;

  // ---------------------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ_K     = 50;
  localparam int unsigned REF_MHZ_K       = 8;
  // The 8 MHz reference comes from a phase accumulator on the 50 MHz clock
  localparam logic [5:0]  REF_ACC_INC_K   = 6'(REF_MHZ_K);
  localparam logic [5:0]  REF_ACC_WRAP_K  = 6'(CLOCK_MHZ_K);
  localparam logic [5:0]  REF_ACC_RESET_K = 6'h00;

  // ---------------------------------------------------------------------------
  // Period layout
  // ---------------------------------------------------------------------------
  localparam int unsigned DUTY_W_K        = 8;
  localparam int unsigned STEP_LEN_W_K    = 9;
  localparam logic [7:0]  STEPS_LAST_K    = 8'hFE;
  localparam logic [7:0]  DUTY_FULL_K     = 8'hFF;
  localparam logic [7:0]  DUTY_ZERO_K     = 8'h00;
  localparam logic [7:0]  DUTY_RESET_K    = 8'h00;
  // Reference clocks per step for divider code 00; codes 01..11 halve it each
  localparam logic [8:0]  STEP_BASE_K     = 9'h100;

  // ---------------------------------------------------------------------------
  // Fine trim codes and ratios in percent
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  TRIM_MINUS_K    = 2'h1;
  localparam logic [1:0]  TRIM_PLUS_K     = 2'h2;
  localparam logic [15:0] PCT_NOMINAL_K   = 16'h0064;
  localparam logic [15:0] PCT_MINUS_K     = 16'h0055;
  localparam logic [15:0] PCT_PLUS_K      = 16'h0073;

  // ---------------------------------------------------------------------------
  // Channel source selection
  // ---------------------------------------------------------------------------
  localparam int unsigned CHANNELS_K      = 8;
  localparam int unsigned PAR_INPUTS_K    = 2;
  localparam logic        SEL_GENERAL_K   = 1'b0;
  localparam logic        SEL_LAMP_K      = 1'b1;

  // Step length in reference clocks for a divider code and shared trim code
  function automatic logic [8:0] dcpg_step_len(input logic [1:0] div, input logic [1:0] trim);
    logic [15:0] base;
    logic [15:0] pct;
    logic [15:0] prod;
    base = {7'h00, STEP_BASE_K >> div};
    pct  = (trim == TRIM_MINUS_K) ? PCT_MINUS_K : ((trim == TRIM_PLUS_K) ? PCT_PLUS_K : PCT_NOMINAL_K);
    prod = 16'((base * pct) / PCT_NOMINAL_K);
    return prod[8:0];
  endfunction

endpackage

// file: hw/dcpg_pulse_gen.sv
// One pulse generator with a 255 step period and boundary duty update
`timescale 1ns/1ps
`default_nettype none
module dcpg_pulse_gen
  import dcpg_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_ref_tick,
  input  wire logic [STEP_LEN_W_K-1:0] i_step_len,
  input  wire logic [DUTY_W_K-1:0]     i_duty,
  output logic                         o_pulse,
  output logic                         o_period_start,
  output logic [DUTY_W_K-1:0]          o_active_duty,
  output logic [7:0]                   o_step_index
);

  // ---------------------------------------------------------------------------
  // Step and period counters
  // ---------------------------------------------------------------------------
  logic [STEP_LEN_W_K-1:0] ref_cnt_q;
  logic [STEP_LEN_W_K-1:0] ref_cnt_d;
  logic [7:0]              step_q;
  logic [7:0]              step_d;
  logic [DUTY_W_K-1:0]     active_q;
  logic [DUTY_W_K-1:0]     active_d;
  logic                    pulse_q;
  wire                     step_end;
  wire                     period_end;
  wire                     take_duty;

  // A shortened step length after a divider change ends the step at the next reference tick
  assign step_end   = i_ref_tick && (ref_cnt_q >= i_step_len - 9'h001);
  assign period_end = step_end && (step_q >= STEPS_LAST_K);
  assign ref_cnt_d  = step_end ? '0 : (i_ref_tick ? ref_cnt_q + 9'h001 : ref_cnt_q);
  assign step_d     = period_end ? 8'h00 : (step_end ? step_q + 8'h01 : step_q);
  // Zero duty takes a new value at once, any other only at the boundary
  assign take_duty  = period_end || (active_q == DUTY_ZERO_K);
  assign active_d   = take_duty ? i_duty : active_q;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ref_cnt_q <= '0;
      step_q    <= 8'h00;
      active_q  <= DUTY_RESET_K;
      pulse_q   <= 1'b0;
    end
    else
    begin
      ref_cnt_q <= ref_cnt_d;
      step_q    <= step_d;
      active_q  <= active_d;
      pulse_q   <= (step_d < active_d);
    end
  end

  assign o_pulse        = pulse_q;
  assign o_period_start = period_end;
  assign o_active_duty  = active_q;
  assign o_step_index   = step_q;

endmodule
`default_nettype wire

// file: hw/dcpg_top.sv
// Dual channel pulse generators with channel source routing
`timescale 1ns/1ps
`default_nettype none
module dcpg_top
  import dcpg_pkg::*;
#(
  parameter int unsigned NUM_CHANNELS = CHANNELS_K,
  parameter int unsigned NUM_INPUTS   = PAR_INPUTS_K
)
(
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic [1:0]              i_general_generator_divider,
  input  wire logic [1:0]              i_lamp_generator_divider,
  input  wire logic [1:0]              i_shared_fine_frequency_trim,
  input  wire logic [DUTY_W_K-1:0]     i_general_generator_duty,
  input  wire logic [DUTY_W_K-1:0]     i_lamp_generator_duty,
  input  wire logic [NUM_CHANNELS-1:0] i_generator_select,
  input  wire logic [NUM_CHANNELS-1:0] i_generator_map,
  input  wire logic [NUM_CHANNELS-1:0] i_input_map,
  input  wire logic [NUM_CHANNELS-1:0] i_input_select,
  input  wire logic [NUM_CHANNELS-1:0] i_serial_command,
  input  wire logic [NUM_INPUTS-1:0]   i_parallel_input,
  output logic [NUM_CHANNELS-1:0]      o_channel_command,
  output logic                         o_general_pulse,
  output logic                         o_lamp_pulse,
  output logic                         o_general_period_start,
  output logic                         o_lamp_period_start
);

  // ---------------------------------------------------------------------------
  // Common 8 MHz reference
  // ---------------------------------------------------------------------------
  logic [5:0] ref_acc_q;
  wire  [5:0] ref_acc_sum;
  wire        ref_tick;

  // Fractional accumulator: 8 ticks every 50 clocks, jitter of one clock
  assign ref_acc_sum = ref_acc_q + REF_ACC_INC_K;
  assign ref_tick    = (ref_acc_sum >= REF_ACC_WRAP_K);

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ref_acc_q <= REF_ACC_RESET_K;
    else
      ref_acc_q <= ref_tick ? ref_acc_sum - REF_ACC_WRAP_K : ref_acc_sum;
  end

  // ---------------------------------------------------------------------------
  // Prescalers with shared fine trim
  // ---------------------------------------------------------------------------
  wire [STEP_LEN_W_K-1:0] general_step_len;
  wire [STEP_LEN_W_K-1:0] lamp_step_len;

  // Separate divider per generator, one trim field for both
  assign general_step_len = dcpg_step_len(i_general_generator_divider,
                                          i_shared_fine_frequency_trim);
  assign lamp_step_len    = dcpg_step_len(i_lamp_generator_divider, i_shared_fine_frequency_trim);

  // ---------------------------------------------------------------------------
  // Generators
  // ---------------------------------------------------------------------------
  wire                general_pulse;
  wire                lamp_pulse;
  wire [DUTY_W_K-1:0] general_active;
  wire [DUTY_W_K-1:0] lamp_active;
  wire [7:0]          general_step;
  wire [7:0]          lamp_step;

  dcpg_pulse_gen u_general (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_ref_tick     (ref_tick),
    .i_step_len     (general_step_len),
    .i_duty         (i_general_generator_duty),
    .o_pulse        (general_pulse),
    .o_period_start (o_general_period_start),
    .o_active_duty  (general_active),
    .o_step_index   (general_step)
  );

  dcpg_pulse_gen u_lamp (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_ref_tick     (ref_tick),
    .i_step_len     (lamp_step_len),
    .i_duty         (i_lamp_generator_duty),
    .o_pulse        (lamp_pulse),
    .o_period_start (o_lamp_period_start),
    .o_active_duty  (lamp_active),
    .o_step_index   (lamp_step)
  );

  assign o_general_pulse = general_pulse;
  assign o_lamp_pulse    = lamp_pulse;

  // ---------------------------------------------------------------------------
  // Parallel input synchroniser
  // ---------------------------------------------------------------------------
  logic [NUM_INPUTS-1:0] par_meta_q;
  logic [NUM_INPUTS-1:0] par_sync_q;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      par_meta_q <= '0;
      par_sync_q <= '0;
    end
    else
    begin
      par_meta_q <= i_parallel_input;
      par_sync_q <= par_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Driving tree: generator over parallel input over serial bit
  // ---------------------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] cmd_q;
  wire  [NUM_CHANNELS-1:0] gen_src;
  wire  [NUM_CHANNELS-1:0] pin_src;
  wire  [NUM_CHANNELS-1:0] cmd_d;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1)
    begin : g_chan
      // Code 0 general, code 1 lamp
      assign gen_src[ch] = (i_generator_select[ch] == SEL_LAMP_K) ? lamp_pulse : general_pulse;
      // Only two pins exist, so the select bit picks one of them
      assign pin_src[ch] = par_sync_q[NUM_INPUTS > 1 ? 32'(i_input_select[ch]) : 0];
      assign cmd_d[ch]   = i_generator_map[ch] ? gen_src[ch] :
                           (i_input_map[ch] ? pin_src[ch] : i_serial_command[ch]);
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      cmd_q <= '0;
    else
      cmd_q <= cmd_d;
  end

  assign o_channel_command = cmd_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_GENERAL_FASTEST:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_general_generator_divider == 2'h3 && i_shared_fine_frequency_trim == 2'h0)
      |-> general_step_len == 9'h020)
    else $error("General divider code 11 not 32 reference clocks per step");

  AST_LAMP_TABLE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_shared_fine_frequency_trim == 2'h0) |-> lamp_step_len == (STEP_BASE_K >> i_lamp_generator_divider))
    else $error("Lamp step length does not follow divider code");

  AST_SHARED_TRIM:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_lamp_generator_divider == 2'h0 && i_shared_fine_frequency_trim == 2'h1) |-> lamp_step_len == 9'h0D9)
    else $error("Lamp generator ignores shared trim");

  AST_TRIM_PLUS:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_general_generator_divider == 2'h0 && i_shared_fine_frequency_trim == 2'h2) |-> general_step_len == 9'h126)
    else $error("Plus trim does not lengthen step by 15 percent");

  AST_REF_RATE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      ref_tick |=> !ref_tick ##1 !ref_tick ##1 !ref_tick ##1 !ref_tick ##1 !ref_tick)
    else $error("Reference ticks too close for 8 MHz");

  AST_FULL_ON:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (general_active == DUTY_FULL_K) [*2] |-> general_pulse)
    else $error("Full duty output not continuously on");

  AST_ZERO_OFF:
    assert property (@(posedge i_clock) disable iff (i_rst)
      ($past(lamp_active) == DUTY_ZERO_K && lamp_active == DUTY_ZERO_K) |-> !lamp_pulse)
    else $error("Zero duty output not off");

  AST_DUTY_STEP:
    assert property (@(posedge i_clock) disable iff (i_rst)
      $stable(general_active) && $stable(general_step) && !$past(i_rst) |->
      general_pulse == (general_step < general_active))
    else $error("Output not on for duty steps of the period");

  AST_DEFER:
    assert property (@(posedge i_clock) disable iff (i_rst)
      $changed(general_active) |-> $past(o_general_period_start) || $past(general_active) == DUTY_ZERO_K)
    else $error("Duty changed inside a running period");

  AST_ZERO_IMMEDIATE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      lamp_active == DUTY_ZERO_K && !$past(i_rst) |=> lamp_active == $past(i_lamp_generator_duty))
    else $error("New duty not taken at once from zero duty");

  AST_PERIOD_LEN:
    assert property (@(posedge i_clock) disable iff (i_rst)
      lamp_step <= STEPS_LAST_K)
    else $error("Step index past 255 steps");

  AST_ROUTE_GENERAL:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_generator_map[0] && i_generator_select[0] == SEL_GENERAL_K) |=> o_channel_command[0] == $past(general_pulse))
    else $error("Mapped channel not driven by general generator");

  AST_ROUTE_LAMP:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_generator_map[1] && i_generator_select[1] == SEL_LAMP_K) |=> o_channel_command[1] == $past(lamp_pulse))
    else $error("Mapped channel not driven by lamp generator");

  AST_SERIAL_SRC:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (!i_generator_map[2] && !i_input_map[2]) |=> o_channel_command[2] == $past(i_serial_command[2]))
    else $error("Unmapped channel not driven by serial bit");

  AST_LAMP_FULL_ON:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (lamp_active == DUTY_FULL_K) [*2] |-> lamp_pulse)
    else $error("Full duty lamp output not continuously on");

  AST_GENERAL_ZERO_OFF:
    assert property (@(posedge i_clock) disable iff (i_rst)
      ($past(general_active) == DUTY_ZERO_K && general_active == DUTY_ZERO_K) |-> !general_pulse)
    else $error("Zero duty general output not off");

  AST_LAMP_DEFER:
    assert property (@(posedge i_clock) disable iff (i_rst)
      $changed(lamp_active) |-> $past(o_lamp_period_start) || $past(lamp_active) == DUTY_ZERO_K)
    else $error("Lamp duty changed inside a running period");

  AST_GENERAL_ZERO_IMMEDIATE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      general_active == DUTY_ZERO_K && !$past(i_rst) |=> general_active == $past(i_general_generator_duty))
    else $error("New general duty not taken at once from zero duty");

  AST_GENERAL_BOUNDARY:
    assert property (@(posedge i_clock) disable iff (i_rst)
      o_general_period_start |=> general_active == $past(i_general_generator_duty))
    else $error("General duty not loaded at period start");

  AST_LAMP_BOUNDARY:
    assert property (@(posedge i_clock) disable iff (i_rst)
      o_lamp_period_start |=> lamp_active == $past(i_lamp_generator_duty))
    else $error("Lamp duty not loaded at period start");

  AST_START_SINGLE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      o_general_period_start |=> !o_general_period_start)
    else $error("General period start longer than one cycle");

  AST_PERIOD_WRAP:
    assert property (@(posedge i_clock) disable iff (i_rst)
      o_lamp_period_start |-> lamp_step == STEPS_LAST_K ##1 lamp_step == 8'h00)
    else $error("Lamp period does not wrap after 255 steps");

  AST_TRIM_MINUS:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_general_generator_divider == 2'h3 && i_shared_fine_frequency_trim == 2'h1) |-> general_step_len == 9'h01B)
    else $error("Minus trim does not shorten step by 15 percent");

  AST_TRIM_NEUTRAL:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_shared_fine_frequency_trim == 2'h3) |-> general_step_len == (9'h100 >> i_general_generator_divider))
    else $error("Trim code 11 changes the step length");

  AST_GENERAL_TABLE:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (i_shared_fine_frequency_trim == 2'h0) |-> general_step_len == (9'h100 >> i_general_generator_divider))
    else $error("General step length does not follow divider code");

  AST_REF_GAP:
    assert property (@(posedge i_clock) disable iff (i_rst)
      ref_tick |=> ##[0:6] ref_tick)
    else $error("Reference ticks too far apart for 8 MHz");

  AST_ROUTE_PIN:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (!i_generator_map[3] && i_input_map[3]) |=> o_channel_command[3] == $past(pin_src[3]))
    else $error("Input mapped channel not driven by its pin");

endmodule
`default_nettype wire

// file: sim/dcpg_stage_model.sv
// Power stage stand-in that follows the channel commands
`timescale 1ns/1ps
`default_nettype none
module dcpg_stage_model
  import dcpg_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic [CHANNELS_K-1:0] i_channel_command,
  output logic      [CHANNELS_K-1:0] o_stage_on,
  output logic      [15:0]           o_turn_on_count
);
  // ---------------------------------------------------------------------------
  // Stage state
  // ---------------------------------------------------------------------------
  // One clock of switching delay; the real stages take microseconds, only order matters here
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_stage_on      <= '0;
      o_turn_on_count <= 16'h0000;
    end
    else
    begin
      o_stage_on <= i_channel_command;
      // Counts switch-on events of channel 1 only, enough to spot glitches
      if (i_channel_command[1] && !o_stage_on[1])
        o_turn_on_count <= o_turn_on_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: sim/dual_channel_pwm_generators_tb.sv
// Self-checking bench for the dual pulse generators
`timescale 1ns/1ps
`default_nettype none
module dual_channel_pwm_generators_tb;
  import dcpg_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------------------
  logic        i_clock     = 1'b0;
  logic        i_rst       = 1'b1;
  logic [1:0]  gen_div     = 2'h3;
  logic [1:0]  lamp_div    = 2'h3;
  logic [1:0]  trim        = 2'h1;
  logic [7:0]  gen_duty    = 8'hFF;
  logic [7:0]  lamp_duty   = 8'h00;
  logic [7:0]  gen_sel     = 8'h00;
  logic [7:0]  gen_map     = 8'h00;
  logic [7:0]  in_map      = 8'h00;
  logic [7:0]  in_sel      = 8'h00;
  logic [7:0]  serial_cmd  = 8'h00;
  logic [1:0]  pins        = 2'h0;
  logic [7:0]  chan_cmd;
  logic [7:0]  stage_on;
  logic [15:0] on_count;
  logic        gen_pulse;
  logic        lamp_pulse;
  logic        gen_start;
  logic        lamp_start;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          gen_starts  = 0;
  int          hi;

  always #10 i_clock = ~i_clock;

  always @(posedge i_clock)
    if (gen_start === 1'b1)
      gen_starts++;

  dcpg_top uut (
    .i_clock                      (i_clock),
    .i_rst                        (i_rst),
    .i_general_generator_divider  (gen_div),
    .i_lamp_generator_divider     (lamp_div),
    .i_shared_fine_frequency_trim (trim),
    .i_general_generator_duty     (gen_duty),
    .i_lamp_generator_duty        (lamp_duty),
    .i_generator_select           (gen_sel),
    .i_generator_map              (gen_map),
    .i_input_map                  (in_map),
    .i_input_select               (in_sel),
    .i_serial_command             (serial_cmd),
    .i_parallel_input             (pins),
    .o_channel_command            (chan_cmd),
    .o_general_pulse              (gen_pulse),
    .o_lamp_pulse                 (lamp_pulse),
    .o_general_period_start       (gen_start),
    .o_lamp_period_start          (lamp_start)
  );

  dcpg_stage_model stage (
    .i_clock           (i_clock),
    .i_rst             (i_rst),
    .i_channel_command (chan_cmd),
    .o_stage_on        (stage_on),
    .o_turn_on_count   (on_count)
  );

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic write_duty(input logic [7:0] g, input logic [7:0] l);
    @(posedge i_clock);
    gen_duty  <= g;
    lamp_duty <= l;
  endtask

  task automatic write_route(input logic [7:0] sel, input logic [7:0] map, input logic [7:0] imap,
                             input logic [7:0] isel, input logic [7:0] ser, input logic [1:0] p);
    @(posedge i_clock);
    gen_sel    <= sel;
    gen_map    <= map;
    in_map     <= imap;
    in_sel     <= isel;
    serial_cmd <= ser;
    pins       <= p;
  endtask

  // Bounded so a stuck divider cannot hang the run
  task automatic wait_start(input bit lamp);
    int n;
    n = 0;
    @(negedge i_clock);
    while (((lamp ? lamp_start : gen_start) !== 1'b1) && n < 50000)
    begin
      @(negedge i_clock);
      n++;
    end
    check(n < 50000, 1'b1);
    @(negedge i_clock);
    check(lamp ? lamp_start : gen_start, 1'b0);
  endtask

  task automatic conclude;
    $display("Counts: comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    // Tests need about 65000 clocks
    #(20 * 90000);
    fail_count++;
    conclude();
  end

  initial
  begin
    idle(12);
    i_rst <= 1'b0;
    idle(4);
    @(negedge i_clock);
    check(gen_pulse, 1'b1);
    check(lamp_pulse, 1'b0);
    $display("test reset_load done");
    // Select before map, as software must
    write_route(8'h02, 8'h00, 8'h0C, 8'h08, 8'hF0, 2'h2);
    write_route(8'h02, 8'h03, 8'h0C, 8'h08, 8'hF0, 2'h2);
    idle(4);
    @(negedge i_clock);
    check(chan_cmd, 8'hF9);
    check(stage_on, 8'hF9);
    write_route(8'h02, 8'h03, 8'h0C, 8'h08, 8'hF0, 2'h1);
    idle(4);
    @(negedge i_clock);
    check(chan_cmd, 8'hF5);
    $display("test routing done");
    write_duty(8'hFF, 8'hFF);
    idle(2);
    @(negedge i_clock);
    check(lamp_pulse, 1'b1);
    idle(3);
    @(negedge i_clock);
    check(chan_cmd, 8'hF7);
    check(on_count, 16'h0001);
    write_route(8'h02, 8'h01, 8'h0C, 8'h08, 8'hF0, 2'h1);
    idle(4);
    @(negedge i_clock);
    check(chan_cmd, 8'hF5);
    $display("test immediate_load done");
    write_duty(8'h00, 8'h80);
    idle(200);
    @(negedge i_clock);
    check(gen_pulse, 1'b1);
    check(lamp_pulse, 1'b1);
    gen_starts = 0;
    wait_start(1'b1);
    check(gen_starts, 32'h0000_0001);
    // 128 steps of 27 ticks at 6.25 clocks a tick, one tick of slack
    hi = 1;
    while (lamp_pulse === 1'b1 && hi < 30000)
    begin
      @(negedge i_clock);
      hi++;
    end
    check(hi >= 21592 && hi <= 21608, 1'b1);
    check(hi >= 21592 && hi <= 21608, 1'b1);
    if (gen_starts == 0)
      wait_start(1'b0);
    @(negedge i_clock);
    check(gen_pulse, 1'b0);
    $display("test boundary_update done");
    write_route(8'h02, 8'h00, 8'h00, 8'h00, 8'hA5, 2'h3);
    idle(4);
    @(negedge i_clock);
    check(chan_cmd, 8'hA5);
    // Walk every divider and trim code so the step length checks see them all
    for (int k = 0; k < 16; k++)
    begin
      @(posedge i_clock);
      gen_div  <= 2'(k);
      lamp_div <= 2'(k);
      trim     <= 2'(k >> 2);
      idle(2);
    end
    $display("test serial_and_trim done");
    conclude();
  end
endmodule
`default_nettype wire
